// *** dv/adc_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_model import ha_path_pkg::*; (
    // Converter side
    input  wire logic CLK,
    output logic      ADC_VALID,
    output wire adc_t ADC_IN
);
    logic [59:0] idle = 60'h0;
    adc_t        smp;
    initial ADC_VALID = 1'b0;
    // Idle lines change every cycle so a stale sample is never reused
    always @(posedge CLK) idle <= ~idle;
    assign ADC_IN = ADC_VALID ? smp : adc_t'(idle);
    task automatic send(input logic [19:0] f);
        @(posedge CLK);
        smp <= '{front: f, mic2: 20'h0, tcoil: 20'h0};
        ADC_VALID <= 1'b1;
        @(posedge CLK);
        ADC_VALID <= 1'b0;
    endtask : send
endmodule : adc_model
`default_nettype wire

// *** dv/tb_hearing_aid_audio_path.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_hearing_aid_audio_path import ha_path_pkg::*;;
    logic        CLK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, r;
    logic        PREADY, PSLVERR, e, DAC_VALID, ADC_VALID;
    logic [19:0] DAC_DATA;
    logic [2:0]  FBC_STEP;
    adc_t        ADC_IN;
    int          miscompares = 0, comparisons = 0, cycles = 0, pulses = 0, n;
    always #50 CLK = ~CLK;
    adc_model adc_model_i (.CLK(CLK), .ADC_VALID(ADC_VALID), .ADC_IN(ADC_IN));
    hearing_aid_audio_path #(.TICK(4)) hearing_aid_audio_path_i (.CLK(CLK), .RESETN(RESETN),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ADC_VALID(ADC_VALID),
        .ADC_IN(ADC_IN), .DAC_VALID(DAC_VALID), .DAC_DATA(DAC_DATA), .FBC_STEP(FBC_STEP));
    always @(posedge CLK) begin
        cycles++;
        if (DAC_VALID === 1'b1) pulses++;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic t_regs;
        chk(FBC_STEP, 32'h4);
        apb(1'b0, A_CLIP, 32'h0);
        chk(r, 32'h7ffff);
        apb(1'b0, 12'h040, 32'h0);
        chk({r[0], e}, 32'h1);
        apb(1'b1, A_ADAPT, 32'h320);
        apb(1'b0, A_ADAPT, 32'h0);
        chk(r[11:8], 32'h8);
        chk(FBC_STEP, 32'h2);
        apb(1'b1, A_ADAPT, 32'h420);
        apb(1'b0, A_ADAPT, 32'h0);
        chk(r[11:8], 32'h4);
        $display("test regs done");
    endtask : t_regs
    task automatic t_path;
        apb(1'b1, A_CLIP, 32'h10);
        adc_model_i.send(20'h7ffff);
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (DAC_VALID !== 1'b1 && n < 40);
        chk(n, 32'd14);
        chk($signed(DAC_DATA) <= 16 && $signed(DAC_DATA) >= -16, 32'h1);
        adc_model_i.send(20'h00100);
        adc_model_i.send(20'h00100);
        repeat (20) @(posedge CLK);
        apb(1'b0, A_STAT, 32'h0);
        chk(r[1], 32'h1);
        apb(1'b1, A_STAT, 32'h2);
        apb(1'b0, A_STAT, 32'h0);
        chk(r[1], 32'h0);
        $display("test path done");
    endtask : t_path
    task automatic t_rate16;
        apb(1'b1, A_CTRL, 32'h3);
        n = pulses;
        repeat (2) begin
            adc_model_i.send(20'h00200);
            repeat (20) @(posedge CLK);
        end
        chk(pulses - n, 32'd1);
        $display("test rate16 done");
    endtask : t_rate16
    task automatic t_scene;
        @(posedge CLK);
        RESETN <= 1'b0;
        repeat (2) @(posedge CLK);
        RESETN <= 1'b1;
        chk(FBC_STEP, 32'h4);
        apb(1'b1, A_ADAPT, 32'h860);
        apb(1'b1, A_CTRL, 32'h11);
        chk(FBC_STEP, 32'h6);
        for (n = 1; n <= 16; n++) begin
            adc_model_i.send(20'h00000);
            repeat (16) @(posedge CLK);
            if (n == 4) chk(FBC_STEP, 32'h5);
        end
        chk(FBC_STEP, 32'h2);
        apb(1'b0, A_STAT, 32'h0);
        chk(r[4:2], 32'h0);
        apb(1'b1, A_CTRL, 32'h01);
        repeat (2) @(posedge CLK);
        chk(FBC_STEP, 32'h6);
        $display("test scene done");
    endtask : t_scene
    task automatic report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (2) @(posedge CLK);
        RESETN <= 1'b1;
        t_regs();
        t_path();
        t_rate16();
        t_scene();
        report_and_stop();
    end
endmodule : tb_hearing_aid_audio_path
`default_nettype wire

// *** rtl/ha_path_pkg.sv ***
package ha_path_pkg;
    localparam int DW    = 20;
    localparam int CW    = 16;
    localparam int CFRAC = 14;
    localparam int GFRAC = 7;
    localparam int NSEC  = 8;
    localparam int HP_K  = 8;
    localparam int BAND_K = 3;
    localparam int ENV_K = 6;
    localparam int NSH_K = 2;
    localparam int CLS_TICK = 64;
    localparam logic [2:0] SEC_PRE_LAST   = 3'h3;
    localparam logic [2:0] SEC_POST_FIRST = 3'h4;
    localparam logic [2:0] SEC_POST_LAST  = 3'h5;
    localparam logic [2:0] SEC_TAIL_FIRST = 3'h6;
    localparam logic [2:0] SEC_TAIL_LAST  = 3'h7;
    localparam logic [2:0] NCOEF          = 3'h5;
    localparam logic [11:0] A_CTRL  = 12'h000;
    localparam logic [11:0] A_STAT  = 12'h004;
    localparam logic [11:0] A_CADR  = 12'h008;
    localparam logic [11:0] A_CDAT  = 12'h00c;
    localparam logic [11:0] A_GAIN  = 12'h010;
    localparam logic [11:0] A_NOISE = 12'h014;
    localparam logic [11:0] A_COMP  = 12'h018;
    localparam logic [11:0] A_ADAPT = 12'h01c;
    localparam logic [11:0] A_CLIP  = 12'h020;
    localparam int B_RUN = 0;
    localparam int B_R16 = 1;
    localparam int B_TCOIL = 2;
    localparam int B_MIX = 3;
    localparam int B_CLS = 4;
    localparam int B_OVR = 1;
    localparam logic [4:0]  CTRL_RST   = 5'h01;
    localparam logic [15:0] COEF_UNITY = 16'h4000;
    localparam logic [7:0]  GAIN_UNITY = 8'h80;
    localparam logic [18:0] CLIP_RST   = 19'h7ffff;
    localparam logic [19:0] THR_RST    = 20'h10000;
    localparam logic [19:0] QUIET_LVL  = 20'h00400;
    localparam logic [19:0] NOISE_LVL  = 20'h04000;
    localparam logic [19:0] LFSR_SEED  = 20'h00001;
    localparam logic [19:0] LFSR_TAPS  = 20'h90000;
    localparam logic [3:0]  CHAN_RST   = 4'h8;
    localparam logic [2:0]  FBC_RST    = 3'h4;
    localparam logic signed [39:0] SMAX = 40'sh00_0007_ffff;
    localparam logic signed [39:0] SMIN = -40'sh00_0008_0000;
    typedef enum logic [3:0] {
        S_IDLE, S_IIR, S_PRE, S_BAND, S_POST, S_WB, S_VOL, S_TAIL, S_CLIP
    } stage_t;
    typedef enum logic [2:0] {
        SC_QUIET, SC_SPEECH_QUIET, SC_SPEECH_NOISE, SC_MUSIC, SC_NOISE
    } scene_t;
    typedef enum logic [1:0] {INJ_OFF, INJ_PRE_VC, INJ_POST_VC} inj_t;
    typedef struct packed {
        logic signed [DW-1:0] front;
        logic signed [DW-1:0] mic2;
        logic signed [DW-1:0] tcoil;
    } adc_t;
endpackage : ha_path_pkg

// *** rtl/hearing_aid_audio_path.sv ***
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Front microphone is the main input
// - Second input: mic2 or telecoil by selector
// - 20-bit stream at 32 or 16 kHz
// - IIR stage right after rate conversion
// - Four cascaded configurable shaping biquads follow
// - Band analysis, compression, then synthesis
// - Two bands: one-pole low part and high remainder
// - Adaptive noise suppression on the high band only
// - Two trailing biquads, then output gain stage
// - Wideband gain, then volume gain
// - Two more biquads, then peak clipper
// - Clipped stream drives the output bridge
// - White noise shaped, attenuated, injected once
// - Pre-volume point: between wideband and volume
// - Post-volume point: after last biquad
// - Classifier labels five acoustic scenes
// - Scene adjusts suppression, compression, feedback
// - Parameters move to targets in steps
module hearing_aid_audio_path
    import ha_path_pkg::*;
#(
    parameter int TICK = CLS_TICK
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESETN,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Converter samples
    input  wire logic        ADC_VALID,
    input  wire adc_t        ADC_IN,
    // Output bridge and feedback canceller
    output logic             DAC_VALID,
    output logic      [19:0] DAC_DATA,
    output logic      [2:0]  FBC_STEP
);
    function automatic logic signed [DW-1:0] sat(input logic signed [39:0] v);
        if (v > SMAX) return SMAX[DW-1:0];
        if (v < SMIN) return SMIN[DW-1:0];
        return v[DW-1:0];
    endfunction : sat

    function automatic logic signed [DW-1:0] scale(input logic signed [DW-1:0] x,
                                                   input logic [7:0] g);
        logic signed [39:0] p;
        p = 40'(x) * 40'($signed({1'b0, g}));
        return sat(p >>> GFRAC);
    endfunction : scale

    function automatic logic signed [DW-1:0] biq(input logic signed [DW-1:0] x,
        input logic signed [DW-1:0] x1, input logic signed [DW-1:0] x2,
        input logic signed [DW-1:0] y1, input logic signed [DW-1:0] y2,
        input logic [4:0][CW-1:0] c);
        logic signed [39:0] a;
        a = 40'(x) * 40'($signed(c[0])) + 40'(x1) * 40'($signed(c[1]))
          + 40'(x2) * 40'($signed(c[2])) - 40'(y1) * 40'($signed(c[3]))
          - 40'(y2) * 40'($signed(c[4]));
        return sat(a >>> CFRAC);
    endfunction : biq

    function automatic logic [7:0] step8(input logic [7:0] cur, input logic [7:0] tgt);
        if (cur < tgt) return 8'(cur + 8'h01);
        if (cur > tgt) return 8'(cur - 8'h01);
        return cur;
    endfunction : step8

    function automatic logic [19:0] absv(input logic signed [DW-1:0] x);
        return x[DW-1] ? 20'(-x) : 20'(x);
    endfunction : absv

    stage_t                st_ff;
    scene_t                scene_ff;
    logic [2:0]            sec_ff;
    logic [4:0]            ctrl_ff;
    logic                  ovr_ff;
    logic [5:0]            cadr_ff;
    logic [7:0]            wb_ff;
    logic [7:0]            vol_ff;
    logic [1:0]            inj_ff;
    logic [3:0]            natt_ff;
    logic [19:0]           thr_ff;
    logic [7:0]            cg_prog_ff;
    logic [2:0]            nr_prog_ff;
    logic [2:0]            fbc_prog_ff;
    logic [3:0]            chan_ff;
    logic [18:0]           clip_ff;
    logic [4:0][CW-1:0]    coef_ff [0:NSEC-1];
    logic signed [DW-1:0]  x1_ff [0:NSEC-1];
    logic signed [DW-1:0]  x2_ff [0:NSEC-1];
    logic signed [DW-1:0]  y1_ff [0:NSEC-1];
    logic signed [DW-1:0]  y2_ff [0:NSEC-1];
    logic signed [DW-1:0]  acc_ff;
    logic signed [DW-1:0]  held_ff;
    logic                  half_ff;
    logic signed [DW-1:0]  hp_x1_ff;
    logic signed [DW-1:0]  hp_y1_ff;
    logic signed [DW-1:0]  low_ff;
    logic [19:0]           env_ff;
    logic [19:0]           floor_ff;
    logic [19:0]           lfsr_ff;
    logic signed [DW-1:0]  nsh_ff;
    logic [7:0]            cls_cnt_ff;
    logic [2:0]            nr_cur_ff;
    logic [7:0]            cg_cur_ff;
    logic [2:0]            fbc_cur_ff;
    logic [31:0]           prdata_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;
    logic                  dac_valid_ff;
    logic [19:0]           dac_ff;

    // Register access decode
    wire        access = PSEL & PENABLE & ~pready_ff;
    wire        wr     = PSEL & PENABLE & pready_ff & PWRITE & ~pslverr_ff;
    wire        hit    = PADDR == A_CTRL || PADDR == A_STAT || PADDR == A_CADR
                      || PADDR == A_CDAT || PADDR == A_GAIN || PADDR == A_NOISE
                      || PADDR == A_COMP || PADDR == A_ADAPT || PADDR == A_CLIP;
    wire [4:0][CW-1:0] cset = coef_ff[cadr_ff[5:3]];
    wire [15:0] cword  = cadr_ff[2:0] < NCOEF ? cset[cadr_ff[2:0]] : 16'h0000;
    wire [31:0] rdata  =
        PADDR == A_CTRL  ? {27'h0, ctrl_ff} :
        PADDR == A_STAT  ? {24'h0, nr_cur_ff, scene_ff, ovr_ff, st_ff != S_IDLE} :
        PADDR == A_CADR  ? {26'h0, cadr_ff} :
        PADDR == A_CDAT  ? {16'h0, cword} :
        PADDR == A_GAIN  ? {16'h0, vol_ff, wb_ff} :
        PADDR == A_NOISE ? {24'h0, natt_ff, 2'b00, inj_ff} :
        PADDR == A_COMP  ? {4'h0, cg_prog_ff, thr_ff} :
        PADDR == A_ADAPT ? {20'h0, chan_ff, 1'b0, fbc_prog_ff, 1'b0, nr_prog_ff} :
        PADDR == A_CLIP  ? {13'h0, clip_ff} : 32'h0000_0000;
    wire        chan_ok = PWDATA[11:8] == 4'h1 || PWDATA[11:8] == 4'h2
                       || PWDATA[11:8] == 4'h4 || PWDATA[11:8] == 4'h6
                       || PWDATA[11:8] == 4'h8;

    // Input selection and rate conversion
    wire signed [DW-1:0] second  = ctrl_ff[B_TCOIL] ? ADC_IN.tcoil : ADC_IN.mic2;
    wire signed [DW-1:0] in_main = ctrl_ff[B_MIX]
                                 ? DW'((ADC_IN.front >>> 1) + (second >>> 1)) : ADC_IN.front;
    wire signed [DW-1:0] in_avg  = DW'((held_ff >>> 1) + (in_main >>> 1));
    wire        take  = ADC_VALID & ctrl_ff[B_RUN];
    wire        start = take & (~ctrl_ff[B_R16] | half_ff);
    wire        busy  = st_ff != S_IDLE;
    wire        begin_s = start & ~busy;

    // Stage arithmetic
    wire [4:0][CW-1:0]   csec  = coef_ff[sec_ff];
    wire signed [DW-1:0] biq_y = biq(acc_ff, x1_ff[sec_ff], x2_ff[sec_ff],
                                     y1_ff[sec_ff], y2_ff[sec_ff], csec);
    wire signed [DW-1:0] iir_y = sat(40'(acc_ff) - 40'(hp_x1_ff) + 40'(hp_y1_ff)
                                     - 40'(hp_y1_ff >>> HP_K));
    wire [7:0]           cg    = env_ff > thr_ff ? cg_cur_ff : GAIN_UNITY;
    wire [7:0]           nrg   = 8'(GAIN_UNITY - {2'b00, nr_cur_ff, 3'b000});
    wire signed [DW-1:0] lo_n  = sat(40'(low_ff) + ((40'(acc_ff) - 40'(low_ff)) >>> BAND_K));
    wire signed [DW-1:0] hi_n  = sat(40'(acc_ff) - 40'(lo_n));
    wire signed [DW-1:0] band_y = sat(40'(scale(lo_n, cg))
                                    + 40'(scale(scale(hi_n, cg), nrg)));
    wire signed [DW-1:0] noise = nsh_ff >>> natt_ff;
    wire signed [DW-1:0] wb_y  = scale(acc_ff, wb_ff);
    wire signed [DW-1:0] vol_in = inj_ff == INJ_PRE_VC
                                ? sat(40'(acc_ff) + 40'(noise)) : acc_ff;
    wire signed [DW-1:0] vol_y = scale(vol_in, vol_ff);
    wire signed [DW-1:0] clip_in = inj_ff == INJ_POST_VC
                                 ? sat(40'(acc_ff) + 40'(noise)) : acc_ff;
    wire signed [DW-1:0] clipv = $signed({1'b0, clip_ff});
    wire signed [DW-1:0] clip_y = clip_in > clipv ? clipv
                                : (clip_in < -clipv ? DW'(-clipv) : clip_in);
    wire is_biq = st_ff == S_PRE || st_ff == S_POST || st_ff == S_TAIL;
    wire signed [DW-1:0] stage_y = st_ff == S_IIR  ? iir_y  :
                                   st_ff == S_BAND ? band_y :
                                   st_ff == S_WB   ? wb_y   :
                                   st_ff == S_VOL  ? vol_y  : biq_y;
    wire [19:0] lvl = absv(acc_ff);
    wire [19:0] mod = env_ff > floor_ff ? 20'(env_ff - floor_ff) : 20'h00000;

    // Scene classification and targets
    wire scene_t scene_n = env_ff < QUIET_LVL          ? SC_QUIET :
                           mod < (floor_ff >> 2)       ? SC_NOISE :
                           mod < floor_ff              ? SC_MUSIC :
                           floor_ff > NOISE_LVL        ? SC_SPEECH_NOISE : SC_SPEECH_QUIET;
    wire [2:0] nr_tgt  = scene_ff == SC_NOISE        ? 3'h7 :
                         scene_ff == SC_SPEECH_NOISE ? 3'h5 :
                         scene_ff == SC_SPEECH_QUIET ? 3'h1 : 3'h0;
    wire [7:0] cg_tgt  = scene_ff == SC_SPEECH_NOISE || scene_ff == SC_NOISE
                       ? {1'b0, cg_prog_ff[7:1]} : cg_prog_ff;
    wire [2:0] fbc_tgt = scene_ff == SC_MUSIC ? 3'h1 :
                         scene_ff == SC_QUIET ? 3'h2 : fbc_prog_ff;
    wire tick = begin_s && cls_cnt_ff == 8'(TICK - 1);
    wire [7:0] nr_step  = step8({5'h00, nr_cur_ff}, {5'h00, nr_tgt});
    wire [7:0] fbc_step = step8({5'h00, fbc_cur_ff}, {5'h00, fbc_tgt});

    // APB slave
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= access;
            pslverr_ff <= access & ~hit;
            prdata_ff  <= access & ~PWRITE & hit ? rdata : 32'h0000_0000;
        end
    end

    // Software registers
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ctrl_ff <= CTRL_RST;
            ovr_ff <= 1'b0;
            cadr_ff <= 6'h00;
            wb_ff <= GAIN_UNITY;
            vol_ff <= GAIN_UNITY;
            inj_ff <= INJ_OFF;
            natt_ff <= 4'h0;
            thr_ff <= THR_RST;
            cg_prog_ff <= GAIN_UNITY;
            nr_prog_ff <= 3'h0;
            fbc_prog_ff <= FBC_RST;
            chan_ff <= CHAN_RST;
            clip_ff <= CLIP_RST;
            for (int s = 0; s < NSEC; s++) begin
                coef_ff[s] <= {64'h0, COEF_UNITY};
            end
        end else begin
            ovr_ff <= (start & busy) | (ovr_ff & ~(wr && PADDR == A_STAT && PWDATA[B_OVR]));
            if (wr && PADDR == A_CTRL) ctrl_ff <= PWDATA[4:0];
            if (wr && PADDR == A_CADR) cadr_ff <= PWDATA[5:0];
            if (wr && PADDR == A_CDAT && cadr_ff[2:0] < NCOEF) begin
                coef_ff[cadr_ff[5:3]][cadr_ff[2:0]] <= PWDATA[15:0];
            end
            if (wr && PADDR == A_GAIN) begin
                wb_ff <= PWDATA[7:0];
                vol_ff <= PWDATA[15:8];
            end
            if (wr && PADDR == A_NOISE) begin
                inj_ff <= PWDATA[1:0] == 2'h3 ? INJ_OFF : PWDATA[1:0];
                natt_ff <= PWDATA[7:4];
            end
            if (wr && PADDR == A_COMP) begin
                thr_ff <= PWDATA[19:0];
                cg_prog_ff <= PWDATA[27:20];
            end
            if (wr && PADDR == A_ADAPT) begin
                nr_prog_ff <= PWDATA[2:0];
                fbc_prog_ff <= PWDATA[6:4];
                if (chan_ok) chan_ff <= PWDATA[11:8];
            end
            if (wr && PADDR == A_CLIP) clip_ff <= PWDATA[18:0];
        end
    end

    // Stage sequencer
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st_ff <= S_IDLE;
            sec_ff <= 3'h0;
            acc_ff <= '0;
            held_ff <= '0;
            half_ff <= 1'b0;
            dac_valid_ff <= 1'b0;
            dac_ff <= 20'h00000;
        end else begin
            dac_valid_ff <= 1'b0;
            if (take) half_ff <= ~half_ff & ctrl_ff[B_R16];
            if (take) held_ff <= in_main;
            if (!is_biq && st_ff != S_IDLE) acc_ff <= stage_y;
            if (is_biq) acc_ff <= biq_y;
            unique case (st_ff)
                S_IDLE: if (begin_s) begin
                    acc_ff <= ctrl_ff[B_R16] ? in_avg : in_main;
                    st_ff <= S_IIR;
                end
                S_IIR: begin
                    st_ff <= S_PRE;
                    sec_ff <= 3'h0;
                end
                S_PRE: begin
                    st_ff <= sec_ff == SEC_PRE_LAST ? S_BAND : S_PRE;
                    sec_ff <= 3'(sec_ff + 3'h1);
                end
                S_BAND: begin
                    st_ff <= S_POST;
                    sec_ff <= SEC_POST_FIRST;
                end
                S_POST: begin
                    st_ff <= sec_ff == SEC_POST_LAST ? S_WB : S_POST;
                    sec_ff <= sec_ff == SEC_POST_LAST ? sec_ff : 3'(sec_ff + 3'h1);
                end
                S_WB: st_ff <= S_VOL;
                S_VOL: begin
                    st_ff <= S_TAIL;
                    sec_ff <= SEC_TAIL_FIRST;
                end
                S_TAIL: begin
                    st_ff <= sec_ff == SEC_TAIL_LAST ? S_CLIP : S_TAIL;
                    sec_ff <= sec_ff == SEC_TAIL_LAST ? sec_ff : 3'(sec_ff + 3'h1);
                end
                S_CLIP: begin
                    st_ff <= S_IDLE;
                    dac_ff <= clip_y;
                    dac_valid_ff <= 1'b1;
                end
            endcase
        end
    end

    // Filter and band state
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            hp_x1_ff <= '0;
            hp_y1_ff <= '0;
            low_ff <= '0;
            env_ff <= 20'h00000;
            floor_ff <= 20'h00000;
            for (int s = 0; s < NSEC; s++) begin
                x1_ff[s] <= '0;
                x2_ff[s] <= '0;
                y1_ff[s] <= '0;
                y2_ff[s] <= '0;
            end
        end else begin
            if (st_ff == S_IIR) begin
                hp_x1_ff <= acc_ff;
                hp_y1_ff <= iir_y;
            end
            if (is_biq) begin
                x1_ff[sec_ff] <= acc_ff;
                x2_ff[sec_ff] <= x1_ff[sec_ff];
                y1_ff[sec_ff] <= biq_y;
                y2_ff[sec_ff] <= y1_ff[sec_ff];
            end
            if (st_ff == S_BAND) begin
                low_ff <= lo_n;
                env_ff <= lvl > env_ff ? lvl : 20'(env_ff - (env_ff >> ENV_K));
                floor_ff <= env_ff < floor_ff ? env_ff : 20'(floor_ff + 20'h00001);
            end
        end
    end

    // Noise source and scene adaption
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            lfsr_ff <= LFSR_SEED;
            nsh_ff <= '0;
            cls_cnt_ff <= 8'h00;
            scene_ff <= SC_QUIET;
            nr_cur_ff <= 3'h0;
            cg_cur_ff <= GAIN_UNITY;
            fbc_cur_ff <= FBC_RST;
        end else begin
            if (begin_s) begin
                lfsr_ff <= {1'b0, lfsr_ff[19:1]} ^ (lfsr_ff[0] ? LFSR_TAPS : 20'h00000);
                nsh_ff <= sat(40'(nsh_ff) + ((40'($signed(lfsr_ff)) - 40'(nsh_ff)) >>> NSH_K));
                cls_cnt_ff <= tick ? 8'h00 : 8'(cls_cnt_ff + 8'h01);
            end
            if (!ctrl_ff[B_CLS]) begin
                nr_cur_ff <= nr_prog_ff;
                cg_cur_ff <= cg_prog_ff;
                fbc_cur_ff <= fbc_prog_ff;
            end else if (tick) begin
                scene_ff <= scene_n;
                nr_cur_ff <= nr_step[2:0];
                cg_cur_ff <= step8(cg_cur_ff, cg_tgt);
                fbc_cur_ff <= fbc_step[2:0];
            end
        end
    end

    assign PRDATA    = prdata_ff;
    assign PREADY    = pready_ff;
    assign PSLVERR   = pslverr_ff;
    assign DAC_VALID = dac_valid_ff;
    assign DAC_DATA  = dac_ff;
    assign FBC_STEP  = fbc_cur_ff;

    sequence s_pre;
        st_ff == S_PRE [*4];
    endsequence
    sequence s_tail;
        st_ff == S_POST [*2] ##1 st_ff == S_WB ##1 st_ff == S_VOL ##1 st_ff == S_TAIL [*2];
    endsequence
    property p_latency;
        @(posedge CLK) disable iff (!RESETN) begin_s |-> ##14 dac_valid_ff;
    endproperty
    a_latency: assert property (p_latency) else $error("Output latency wrong");
    property p_front;
        @(posedge CLK) disable iff (!RESETN) st_ff == S_IIR |=> s_pre ##1 st_ff == S_BAND;
    endproperty
    a_front: assert property (p_front) else $error("Front stage order wrong");
    property p_back;
        @(posedge CLK) disable iff (!RESETN) st_ff == S_BAND |=> s_tail ##1 st_ff == S_CLIP;
    endproperty
    a_back: assert property (p_back) else $error("Back stage order wrong");
    property p_clip;
        @(posedge CLK) disable iff (!RESETN)
            dac_valid_ff |-> $signed(dac_ff) <= clipv && $signed(dac_ff) >= -clipv;
    endproperty
    a_clip: assert property (p_clip) else $error("Clip level exceeded");
    property p_hold;
        @(posedge CLK) disable iff (!RESETN) !ctrl_ff[B_CLS] |=> nr_cur_ff == $past(nr_prog_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("Parameter moved while idle");
    property p_gradual;
        @(posedge CLK) disable iff (!RESETN) ctrl_ff[B_CLS] && $past(ctrl_ff[B_CLS])
            |-> (cg_cur_ff - $past(cg_cur_ff) <= 8'h01) || ($past(cg_cur_ff) - cg_cur_ff <= 8'h01);
    endproperty
    a_gradual: assert property (p_gradual) else $error("Step too large");
    property p_overrun;
        @(posedge CLK) disable iff (!RESETN) start && busy |=> ovr_ff && st_ff != S_IIR;
    endproperty
    a_overrun: assert property (p_overrun) else $error("Overrun not flagged");
    property p_half;
        @(posedge CLK) disable iff (!RESETN)
            ctrl_ff[B_R16] && $stable(ctrl_ff) && begin_s ##1 take [*1] |-> !start;
    endproperty
    a_half: assert property (p_half) else $error("Half rate not kept");
    property p_apb;
        @(posedge CLK) disable iff (!RESETN) access |=> pready_ff ##1 !pready_ff;
    endproperty
    a_apb: assert property (p_apb) else $error("Bus answer timing wrong");
endmodule : hearing_aid_audio_path
`default_nettype wire
